// ===== rtl/stbpc_top.sv
// Purpose: target-side bus phase controller for a parallel SCSI peripheral
// Assumes: 20 MHz clock; open-collector bus lines as in/out/enable triples
// Notes: REQ/ACK byte handshake is simplified to one byte per ACK edge
`timescale 1ns/1ps
`default_nettype none
`include "stbpc_defs.svh"
module stbpc_top #(
  parameter int RESEL_TMO_CYC = `STBPC_RESEL_TMO_CYC,
  parameter int RESP_CYC = `STBPC_RESP_CYC,
  parameter int RETRY_GAP_CYC = `STBPC_RETRY_GAP_CYC,
  parameter logic [7:0] OWN_ID_MASK = 8'h01,
  parameter logic [3:0] RETRY_LIMIT = 4'ha
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_BSY,
  output logic O_BSY,
  output logic O_BSY_OE,
  input wire logic I_SEL,
  output logic O_SEL,
  output logic O_SEL_OE,
  input wire logic I_ATN,
  input wire logic I_ACK,
  output logic O_REQ,
  output logic O_REQ_OE,
  output logic O_MSG,
  output logic O_CD,
  output logic O_IO,
  output logic O_PHASE_OE,
  input wire logic [7:0] I_DB,
  output logic [7:0] O_DB,
  output logic O_DB_OE,
  input wire logic I_RESEL_REQ,
  input wire logic I_PHASE_VALID,
  input wire logic [2:0] I_PHASE,
  input wire logic I_SYNC_EN,
  input wire logic I_DONE,
  input wire logic I_ABORT,
  output logic O_SYNC_ACTIVE,
  output logic O_CMD_REJECT,
  output logic O_SELECTED,
  output logic O_RESEL_FAIL,
  output logic O_ERR_DISC,
  output logic O_IN_READY,
  input wire logic I_IN_VALID,
  input wire logic [7:0] I_IN_DATA,
  output logic O_OUT_VALID,
  input wire logic I_OUT_READY,
  output logic [7:0] O_OUT_DATA
);
  localparam int SETTLE_CYC = `STBPC_SETTLE_CYC;
  localparam int ARB_CYC = `STBPC_ARB_CYC;
  localparam int CW = 24;

  // Two-stage synchronisers for every bus input
  logic [11:0] sync1_reg, sync2_reg;
  logic bsy_s, sel_s, atn_s, ack_s, ack_d_reg;
  logic [7:0] db_s;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ack_d_reg <= 1'b0;
    end else if (I_CE) begin
      sync1_reg <= {I_BSY, I_SEL, I_ATN, I_ACK, I_DB};
      sync2_reg <= sync1_reg;
      ack_d_reg <= ack_s;
    end
  end
  assign {bsy_s, sel_s, atn_s, ack_s, db_s} = sync2_reg;

  function automatic logic legal_phase(input logic [2:0] ph, input logic cmd_done);
    legal_phase = !(ph[2] && !ph[1]) && !(ph == stbpc_pkg::STBPC_PH_COMMAND && cmd_done);
  endfunction

  function automatic logic [CW-1:0] cnt_inc(input logic [CW-1:0] c);
    cnt_inc = (c == '1) ? c : c + CW'(1);
  endfunction

  stbpc_pkg::stbpc_state_t st_reg, st_next;
  stbpc_pkg::stbpc_phase_t ph_reg, ph_next;
  logic [CW-1:0] cnt_reg, cnt_next, quiet_reg, quiet_next, tmo_reg, tmo_next;
  logic [3:0] tries_reg, tries_next;
  logic cmd_done_reg, cmd_done_next, req_reg, req_next, db_oe_reg, db_oe_next;
  logic [7:0] db_reg, db_next;
  logic bsy_reg, bsy_next, sel_reg, sel_next, io_oe_reg, io_oe_next;
  logic selected_reg, selected_next, fail_reg, fail_next, err_reg, err_next;
  logic rej_reg, rej_next, resel_pend_reg, resel_pend_next;
  logic bus_free;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_in_data, fifo_out_data;
  logic ack_rise, dir_in, in_xfer, flush;

  // Quiet timer: bus free needs select and busy low for a full settle
  assign bus_free = (quiet_reg >= CW'(SETTLE_CYC));
  assign ack_rise = ack_s && !ack_d_reg;
  assign in_xfer = (st_reg == stbpc_pkg::STBPC_ST_XFER);
  assign dir_in = ph_reg[0];

  always_comb begin
    quiet_next = (bsy_s || sel_s) ? '0 : cnt_inc(quiet_reg);
    st_next = st_reg;
    ph_next = ph_reg;
    cnt_next = cnt_inc(cnt_reg);
    tmo_next = cnt_inc(tmo_reg);
    tries_next = tries_reg;
    cmd_done_next = cmd_done_reg;
    req_next = req_reg;
    db_oe_next = 1'b0;
    db_next = db_reg;
    bsy_next = bsy_reg;
    sel_next = sel_reg;
    io_oe_next = io_oe_reg;
    selected_next = 1'b0;
    fail_next = 1'b0;
    err_next = 1'b0;
    rej_next = 1'b0;
    resel_pend_next = resel_pend_reg || I_RESEL_REQ;
    flush = 1'b0;
    case (st_reg)
      stbpc_pkg::STBPC_ST_IDLE: begin
        // Disconnected: drive nothing
        bsy_next = 1'b0;
        sel_next = 1'b0;
        io_oe_next = 1'b0;
        req_next = 1'b0;
        if (sel_s && !bsy_s && ((db_s & OWN_ID_MASK) != 8'h00) && !sync2_reg[8+0]) begin
          st_next = stbpc_pkg::STBPC_ST_SELECTED;
          cnt_next = '0;
        end else if (bus_free && resel_pend_reg) begin
          st_next = stbpc_pkg::STBPC_ST_FREE;
          cnt_next = '0;
        end
      end
      stbpc_pkg::STBPC_ST_FREE: begin
        // Arbitration starts after the bus free delay; win assumed one settle later
        if (!bus_free) begin
          st_next = stbpc_pkg::STBPC_ST_IDLE;
        end else if (cnt_reg >= CW'(2 * SETTLE_CYC)) begin
          st_next = stbpc_pkg::STBPC_ST_ARB;
          bsy_next = 1'b1;
          cnt_next = '0;
        end
      end
      stbpc_pkg::STBPC_ST_ARB: begin
        db_oe_next = 1'b1;
        db_next = OWN_ID_MASK;
        if (cnt_reg >= CW'(SETTLE_CYC)) begin
          sel_next = 1'b1;
          st_next = stbpc_pkg::STBPC_ST_RESEL;
          cnt_next = '0;
        end
      end
      stbpc_pkg::STBPC_ST_RESEL: begin
        // Hold busy and select a clear plus settle before io asserts
        db_oe_next = 1'b1;
        if (cnt_reg >= CW'(ARB_CYC)) begin
          io_oe_next = 1'b1;
          bsy_next = 1'b0;
          ph_next = stbpc_pkg::STBPC_PH_MSG_IN;
          st_next = stbpc_pkg::STBPC_ST_RESEL_WAIT;
          tmo_next = '0;
        end
      end
      stbpc_pkg::STBPC_ST_RESEL_WAIT: begin
        db_oe_next = 1'b1;
        if (bsy_s && tmo_reg >= CW'(2)) begin
          // Skip own busy echo in the synchroniser
          bsy_next = 1'b1;
          sel_next = 1'b0;
          db_oe_next = 1'b0;
          st_next = stbpc_pkg::STBPC_ST_XFER;
          resel_pend_next = 1'b0;
          tries_next = '0;
          req_next = 1'b0;
          cnt_next = '0;
        end else if (tmo_reg >= CW'(RESEL_TMO_CYC)) begin
          // Release without reset: drop everything, count the attempt
          sel_next = 1'b0;
          io_oe_next = 1'b0;
          db_oe_next = 1'b0;
          tries_next = tries_reg + 4'h1;
          cnt_next = '0;
          if (tries_reg + 4'h1 >= RETRY_LIMIT) begin
            fail_next = 1'b1;
            resel_pend_next = 1'b0;
            tries_next = '0;
            st_next = stbpc_pkg::STBPC_ST_IDLE;
          end else begin
            st_next = stbpc_pkg::STBPC_ST_GAP;
          end
        end
      end
      stbpc_pkg::STBPC_ST_GAP: begin
        if (cnt_reg >= CW'(RETRY_GAP_CYC)) begin
          st_next = stbpc_pkg::STBPC_ST_IDLE;
        end
      end
      stbpc_pkg::STBPC_ST_SELECTED: begin
        // Respond with busy at once; start the transfer once the initiator drops select
        bsy_next = 1'b1;
        cmd_done_next = 1'b0;
        selected_next = 1'b1;
        if (!sel_s) begin
          st_next = stbpc_pkg::STBPC_ST_XFER;
          io_oe_next = 1'b1;
          ph_next = atn_s ? stbpc_pkg::STBPC_PH_MSG_OUT : stbpc_pkg::STBPC_PH_COMMAND;
          req_next = 1'b0;
          cnt_next = '0;
        end
      end
      stbpc_pkg::STBPC_ST_XFER: begin
        db_oe_next = dir_in;
        // Lower request on each acknowledge, raise when data can move
        if (req_reg && ack_rise) begin
          req_next = 1'b0;
          cnt_next = '0;
          if (!dir_in) begin
            db_next = db_s;
          end
        end else if (!req_reg && !ack_s && cnt_reg >= CW'(SETTLE_CYC)) begin
          if (dir_in ? fifo_out_valid : fifo_in_ready) begin
            req_next = 1'b1;
            if (dir_in) begin
              db_next = fifo_out_data;
            end
          end
        end
        if (!req_reg && !ack_s && I_PHASE_VALID) begin
          if (legal_phase(I_PHASE, cmd_done_reg)) begin
            ph_next = stbpc_pkg::stbpc_phase_t'(I_PHASE);
            cnt_next = '0;
          end else begin
            rej_next = 1'b1;
          end
        end
        if (ph_reg == stbpc_pkg::STBPC_PH_COMMAND && ack_rise) begin
          cmd_done_next = 1'b1;
        end
        if (I_ABORT || (ph_reg == stbpc_pkg::STBPC_PH_MSG_OUT && ack_rise && (db_s == 8'h06 || db_s == 8'h0c))) begin
          err_next = I_ABORT;
          flush = 1'b1;
          st_next = stbpc_pkg::STBPC_ST_RELEASE;
        end else if (I_DONE && !req_reg && !ack_s) begin
          st_next = stbpc_pkg::STBPC_ST_RELEASE;
        end
      end
      stbpc_pkg::STBPC_ST_RELEASE: begin
        // Everything released in one edge, well inside the clear delay
        bsy_next = 1'b0;
        sel_next = 1'b0;
        io_oe_next = 1'b0;
        req_next = 1'b0;
        db_oe_next = 1'b0;
        st_next = stbpc_pkg::STBPC_ST_IDLE;
      end
      default: begin
        st_next = stbpc_pkg::STBPC_ST_IDLE;
      end
    endcase
    // Data lines let go on bus free
    if (bus_free && !bsy_reg && !sel_reg && st_reg == stbpc_pkg::STBPC_ST_IDLE) begin
      db_oe_next = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_reg <= stbpc_pkg::STBPC_ST_IDLE;
      ph_reg <= stbpc_pkg::STBPC_PH_DATA_OUT;
      cnt_reg <= '0;
      quiet_reg <= '0;
      tmo_reg <= '0;
      tries_reg <= '0;
      cmd_done_reg <= 1'b0;
      req_reg <= 1'b0;
      db_oe_reg <= 1'b0;
      db_reg <= 8'h00;
      bsy_reg <= 1'b0;
      sel_reg <= 1'b0;
      io_oe_reg <= 1'b0;
      selected_reg <= 1'b0;
      fail_reg <= 1'b0;
      err_reg <= 1'b0;
      rej_reg <= 1'b0;
      resel_pend_reg <= 1'b0;
    end else if (I_CE) begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      quiet_reg <= quiet_next;
      tmo_reg <= tmo_next;
      tries_reg <= tries_next;
      cmd_done_reg <= cmd_done_next;
      req_reg <= req_next;
      db_oe_reg <= db_oe_next;
      db_reg <= db_next;
      bsy_reg <= bsy_next;
      sel_reg <= sel_next;
      io_oe_reg <= io_oe_next;
      selected_reg <= selected_next;
      fail_reg <= fail_next;
      err_reg <= err_next;
      rej_reg <= rej_next;
      resel_pend_reg <= resel_pend_next;
    end
  end

  // Bytes from the initiator go in on acknowledge; bytes to it come out
  assign fifo_in_valid = in_xfer && !dir_in && req_reg && ack_rise;
  assign fifo_in_data = db_s;
  assign fifo_out_ready = in_xfer && dir_in && !req_reg && !ack_s && cnt_reg >= CW'(SETTLE_CYC);

  stbpc_fifo #(.WIDTH(`STBPC_FIFO_WIDTH), .DEPTH(`STBPC_FIFO_DEPTH)) u_rx (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_flush(flush),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(O_OUT_VALID),
    .i_out_ready(I_OUT_READY),
    .o_out_data(O_OUT_DATA)
  );

  stbpc_fifo #(.WIDTH(`STBPC_FIFO_WIDTH), .DEPTH(`STBPC_FIFO_DEPTH)) u_tx (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_flush(flush),
    .i_in_valid(I_IN_VALID),
    .o_in_ready(O_IN_READY),
    .i_in_data(I_IN_DATA),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // Phase lines driven only while connected
  assign O_BSY = 1'b1;
  assign O_BSY_OE = bsy_reg;
  assign O_SEL = 1'b1;
  assign O_SEL_OE = sel_reg;
  assign O_REQ = req_reg;
  assign O_REQ_OE = in_xfer;
  assign O_PHASE_OE = io_oe_reg;
  assign O_MSG = io_oe_reg && ph_reg[2];
  assign O_CD = io_oe_reg && ph_reg[1];
  assign O_IO = io_oe_reg && ph_reg[0];
  assign O_DB = db_reg;
  assign O_DB_OE = db_oe_reg;
  assign O_SYNC_ACTIVE = I_SYNC_EN && in_xfer && !ph_reg[1] && !ph_reg[2];
  assign O_CMD_REJECT = rej_reg;
  assign O_SELECTED = selected_reg;
  assign O_RESEL_FAIL = fail_reg;
  assign O_ERR_DISC = err_reg;
endmodule
`default_nettype wire

// ===== rtl/stbpc_defs.svh
// Purpose: timing counts and codes for the target bus phase controller
// Assumes: 20 MHz local clock (50 ns period)
// Notes: least times round up, longest times round down
`ifndef STBPC_DEFS_SVH
`define STBPC_DEFS_SVH

`define STBPC_CLK_NS 50
`define STBPC_SETTLE_NS 400
`define STBPC_CLEAR_NS 800
`define STBPC_RESP_US 500
`define STBPC_RESEL_TMO_MS 250
`define STBPC_RETRY_GAP_US 20
`define STBPC_SETTLE_CYC ((`STBPC_SETTLE_NS + `STBPC_CLK_NS - 1) / `STBPC_CLK_NS)
`define STBPC_CLEAR_CYC (`STBPC_CLEAR_NS / `STBPC_CLK_NS)
`define STBPC_ARB_CYC (((`STBPC_SETTLE_NS + `STBPC_CLEAR_NS) + `STBPC_CLK_NS - 1) / `STBPC_CLK_NS)
`define STBPC_RESP_CYC ((`STBPC_RESP_US * 1000) / `STBPC_CLK_NS)
`define STBPC_RESEL_TMO_CYC ((`STBPC_RESEL_TMO_MS * 1000000) / `STBPC_CLK_NS)
`define STBPC_RETRY_GAP_CYC ((`STBPC_RETRY_GAP_US * 1000 + `STBPC_CLK_NS - 1) / `STBPC_CLK_NS)
`define STBPC_RETRY_MIN 4
`define STBPC_RETRY_MAX 10
`define STBPC_FIFO_DEPTH 8
`define STBPC_FIFO_WIDTH 8

`endif

// ===== rtl/stbpc_pkg.sv
// Purpose: types for the target bus phase controller
// Assumes: nothing
// Notes: phase codes are {msg, cd, io}
package stbpc_pkg;
  typedef enum logic [2:0] {
    STBPC_PH_DATA_OUT = 3'h0,
    STBPC_PH_DATA_IN = 3'h1,
    STBPC_PH_COMMAND = 3'h2,
    STBPC_PH_STATUS = 3'h3,
    STBPC_PH_MSG_OUT = 3'h6,
    STBPC_PH_MSG_IN = 3'h7
  } stbpc_phase_t;

  typedef enum logic [8:0] {
    STBPC_ST_IDLE = 9'h001,
    STBPC_ST_FREE = 9'h002,
    STBPC_ST_ARB = 9'h004,
    STBPC_ST_RESEL = 9'h008,
    STBPC_ST_RESEL_WAIT = 9'h010,
    STBPC_ST_SELECTED = 9'h020,
    STBPC_ST_XFER = 9'h040,
    STBPC_ST_RELEASE = 9'h080,
    STBPC_ST_GAP = 9'h100
  } stbpc_state_t;
endpackage

// ===== rtl/stbpc_mem.sv
// Purpose: small memory with registered read data
// Assumes: single clock, one write and one read port
// Notes: read data is valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module stbpc_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
    if (i_ce && i_re) begin
      o_rdata <= mem_reg[i_raddr];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/stbpc_fifo.sv
// Purpose: byte FIFO between the bus data lines and the user side
// Assumes: show-ahead output held in a register
// Notes: ready on the write side is the honest not-full flag
`timescale 1ns/1ps
`default_nettype none
module stbpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] count;
  logic outv_reg, outv_next;
  logic do_wr, do_rd, mem_has;
  logic [WIDTH-1:0] rdata;

  assign count = wptr_reg - rptr_reg;
  assign mem_has = (count != '0);
  // Output register counts as one slot, so full covers memory only
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = mem_has && (!outv_reg || (o_out_valid && i_out_ready));
  assign o_out_valid = outv_reg;

  always_comb begin
    wptr_next = wptr_reg + (AW+1)'(do_wr);
    rptr_next = rptr_reg + (AW+1)'(do_rd);
    outv_next = do_rd ? 1'b1 : (i_out_ready ? 1'b0 : outv_reg);
    if (i_flush) begin
      wptr_next = '0;
      rptr_next = '0;
      outv_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      outv_reg <= 1'b0;
    end else if (i_ce) begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      outv_reg <= outv_next;
    end
  end

  stbpc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(do_wr),
    .i_waddr(wptr_reg[AW-1:0]),
    .i_wdata(i_in_data),
    .i_re(do_rd),
    .i_raddr(rptr_reg[AW-1:0]),
    .o_rdata(rdata)
  );

  assign o_out_data = rdata;
endmodule
`default_nettype wire

// ===== dv/stbpc_checker.sv
// Purpose: port-level timing checks for the target bus phase controller
// Assumes: bus inputs are wired line levels, true high
// Notes: counters stand in for spans too long for a repetition
`timescale 1ns/1ps
`default_nettype none
`include "stbpc_defs.svh"
module stbpc_checker #(
  parameter int RESEL_TMO_CYC = 200
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_BSY,
  input wire logic I_SEL,
  input wire logic I_ATN,
  input wire logic I_SYNC_EN,
  input wire logic O_BSY_OE,
  input wire logic O_SEL_OE,
  input wire logic O_REQ,
  input wire logic O_REQ_OE,
  input wire logic O_MSG,
  input wire logic O_CD,
  input wire logic O_IO,
  input wire logic O_PHASE_OE,
  input wire logic O_DB_OE,
  input wire logic O_CMD_REJECT,
  input wire logic O_ERR_DISC,
  input wire logic O_SYNC_ACTIVE
);
  localparam int SETTLE = `STBPC_SETTLE_CYC;
  localparam int CLEAR = `STBPC_CLEAR_CYC;
  localparam int ARB = `STBPC_ARB_CYC;
  logic [7:0] quiet_reg, quiet_next, both_reg, both_next;
  int wait_reg, wait_next;
  // Quiet and both counters saturate, so a long idle bus never wraps back under a limit
  always_comb begin
    quiet_next = (I_BSY || I_SEL) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hff};
    both_next = (O_BSY_OE && O_SEL_OE) ? both_reg + {7'h00, both_reg != 8'hff} : 8'h00;
    wait_next = (O_SEL_OE && !O_BSY_OE) ? wait_reg + 1 : 0;
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      quiet_reg <= 8'h00;
      both_reg <= 8'h00;
      wait_reg <= 0;
    end else begin
      quiet_reg <= quiet_next;
      both_reg <= both_next;
      wait_reg <= wait_next;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_answered;
    O_SEL_OE && O_PHASE_OE && !O_BSY_OE && I_BSY;
  endsequence
  sequence s_given_up;
    $fell(O_SEL_OE) && !O_BSY_OE;
  endsequence
  a_phase_idle: assert property (!O_PHASE_OE |-> {O_MSG, O_CD, O_IO} == 3'h0) else $error("phase lines set");
  a_no_reserved: assert property (O_PHASE_OE |-> !(O_MSG && !O_CD)) else $error("reserved phase shown");
  a_free_first: assert property ($rose(O_BSY_OE) && !$past(I_SEL) |-> quiet_reg >= SETTLE) else $error("early arb");
  a_quiet_release: assert property (quiet_reg >= SETTLE + CLEAR |-> !O_DB_OE && !O_PHASE_OE && !O_REQ_OE) else $error("not released");
  a_resel_io_wait: assert property ($rose(O_PHASE_OE) && O_SEL_OE |-> both_reg >= ARB) else $error("io too early");
  a_sel_drop: assert property (s_answered |-> ##[1:10] !O_SEL_OE) else $error("select held");
  a_first_req: assert property (s_answered |-> ##[1:1000] O_REQ) else $error("no first req");
  a_entry_phase: assert property ($rose(O_PHASE_OE) && !O_SEL_OE |-> {O_MSG, O_CD, O_IO} == (I_ATN ? 3'h6 : 3'h2)) else $error("entry phase");
  a_resel_limit: assert property (wait_reg <= RESEL_TMO_CYC + 4) else $error("resel too long");
  a_tmo_span: assert property (s_given_up |-> wait_reg >= RESEL_TMO_CYC - 4) else $error("gave up early");
  a_retry_gap: assert property (s_given_up |=> !O_BSY_OE [*8]) else $error("retry too soon");
  a_reject_hold: assert property (O_CMD_REJECT |-> $stable({O_MSG, O_CD, O_IO}) ##1 $stable({O_MSG, O_CD, O_IO})) else $error("phase moved");
  a_abort_free: assert property (O_ERR_DISC |-> ##[0:1] !(O_BSY_OE || O_SEL_OE || O_PHASE_OE || O_DB_OE)) else $error("abort kept bus");
  a_sync_data: assert property (O_SYNC_ACTIVE |-> I_SYNC_EN && O_PHASE_OE && !O_MSG && !O_CD) else $error("sync outside data");
  a_req_phase: assert property (O_REQ |-> O_REQ_OE && O_PHASE_OE) else $error("req without phase");
endmodule
bind stbpc_top stbpc_checker #(.RESEL_TMO_CYC(RESEL_TMO_CYC)) i_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_BSY(I_BSY), .I_SEL(I_SEL), .I_ATN(I_ATN), .I_SYNC_EN(I_SYNC_EN), .O_BSY_OE(O_BSY_OE), .O_SEL_OE(O_SEL_OE),
  .O_REQ(O_REQ), .O_REQ_OE(O_REQ_OE), .O_MSG(O_MSG), .O_CD(O_CD), .O_IO(O_IO), .O_PHASE_OE(O_PHASE_OE),
  .O_DB_OE(O_DB_OE), .O_CMD_REJECT(O_CMD_REJECT), .O_ERR_DISC(O_ERR_DISC), .O_SYNC_ACTIVE(O_SYNC_ACTIVE));
`default_nettype wire

// ===== dv/stbpc_host.sv
// Purpose: behavioural initiator on the far side of the bus
// Assumes: terminated lines, so a released line reads false
// Notes: slow adds cycles before each acknowledge
`timescale 1ns/1ps
`default_nettype none
module stbpc_host (
  input wire logic i_clk,
  input wire logic i_bsy,
  input wire logic i_sel,
  input wire logic i_req,
  input wire logic i_io,
  input wire logic [7:0] i_db,
  output logic o_bsy,
  output logic o_sel,
  output logic o_atn,
  output logic o_ack,
  output logic [7:0] o_db,
  output logic o_rx,
  output logic [7:0] o_rx_byte
);
  logic [7:0] tx_q[$];
  logic [7:0] sent_q[$];
  logic answer = 1'b1;
  int slow = 0;
  initial begin
    {o_sel, o_atn, o_ack, o_rx} = 4'h0;
    o_db = 8'h00;
    o_rx_byte = 8'h00;
  end
  task automatic select(input logic atn);
    @(negedge i_clk);
    o_db = 8'h01;
    o_sel = 1'b1;
    o_atn = atn;
    for (int n = 0; n < 300 && i_bsy !== 1'b1; n++) @(negedge i_clk);
    o_sel = 1'b0;
    o_db = 8'h00;
  endtask
  // Answers a reselection with busy, lets go once select has dropped
  always @(negedge i_clk) begin
    o_bsy <= (answer && i_sel && i_io && !i_bsy) || (o_bsy === 1'b1 && i_sel);
  end
  always begin
    @(negedge i_clk);
    if (i_req === 1'b1 && !o_ack) begin
      repeat (slow) @(negedge i_clk);
      if (i_io) begin
        o_rx_byte = i_db;
        o_rx = 1'b1;
      end else begin
        o_db = tx_q.size() ? tx_q.pop_front() : 8'h5a;
        sent_q.push_back(o_db);
      end
      o_ack = 1'b1;
      @(negedge i_clk);
      o_rx = 1'b0;
      for (int n = 0; n < 200 && i_req === 1'b1; n++) @(negedge i_clk);
      o_ack = 1'b0;
      o_db = 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== dv/scsi_target_bus_phase_control_test.sv
// Purpose: self-checking bench for the target bus phase controller
// Assumes: short time-out and gap parameters
// Notes: bus lines are the OR of both parties' drives
`timescale 1ns/1ps
`default_nettype none
module scsi_target_bus_phase_control_test;
  logic I_CLK = 1'b0, I_SYS_RST = 1'b1, I_CE = 1'b1, I_RESEL_REQ = 1'b0, I_PHASE_VALID = 1'b0;
  logic I_SYNC_EN = 1'b0, I_DONE = 1'b0, I_ABORT = 1'b0, I_IN_VALID = 1'b0, I_OUT_READY = 1'b0;
  logic [2:0] I_PHASE = 3'h0;
  logic [7:0] I_IN_DATA = 8'h00;
  logic O_BSY, O_BSY_OE, O_SEL, O_SEL_OE, O_REQ, O_REQ_OE, O_MSG, O_CD, O_IO, O_PHASE_OE, O_DB_OE;
  logic O_SYNC_ACTIVE, O_CMD_REJECT, O_SELECTED, O_RESEL_FAIL, O_ERR_DISC, O_IN_READY, O_OUT_VALID;
  logic [7:0] O_DB, O_OUT_DATA, h_db;
  logic h_bsy, h_sel, h_atn, h_ack, h_rx, drain = 1'b0;
  logic [7:0] h_rx_byte, exp_q[$];
  int miscompares = 0, comparisons = 0, seed = 90203, cnt, acc, prv;
  wire logic I_BSY = h_bsy | (O_BSY_OE & O_BSY);
  wire logic I_SEL = h_sel | (O_SEL_OE & O_SEL);
  wire logic [7:0] I_DB = h_db | (O_DB_OE ? O_DB : 8'h00);
  wire logic [7:0] sts = {O_BSY_OE, O_SEL_OE, O_PHASE_OE, O_DB_OE, O_SELECTED, O_MSG, O_CD, O_IO};
  stbpc_top #(.RESEL_TMO_CYC(200), .RETRY_GAP_CYC(10)) i_dut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE),
    .I_BSY(I_BSY), .O_BSY(O_BSY), .O_BSY_OE(O_BSY_OE), .I_SEL(I_SEL), .O_SEL(O_SEL), .O_SEL_OE(O_SEL_OE),
    .I_ATN(h_atn), .I_ACK(h_ack), .O_REQ(O_REQ), .O_REQ_OE(O_REQ_OE), .O_MSG(O_MSG), .O_CD(O_CD), .O_IO(O_IO),
    .O_PHASE_OE(O_PHASE_OE), .I_DB(I_DB), .O_DB(O_DB), .O_DB_OE(O_DB_OE), .I_RESEL_REQ(I_RESEL_REQ),
    .I_PHASE_VALID(I_PHASE_VALID), .I_PHASE(I_PHASE), .I_SYNC_EN(I_SYNC_EN), .I_DONE(I_DONE), .I_ABORT(I_ABORT),
    .O_SYNC_ACTIVE(O_SYNC_ACTIVE), .O_CMD_REJECT(O_CMD_REJECT), .O_SELECTED(O_SELECTED),
    .O_RESEL_FAIL(O_RESEL_FAIL), .O_ERR_DISC(O_ERR_DISC), .O_IN_READY(O_IN_READY), .I_IN_VALID(I_IN_VALID),
    .I_IN_DATA(I_IN_DATA), .O_OUT_VALID(O_OUT_VALID), .I_OUT_READY(I_OUT_READY), .O_OUT_DATA(O_OUT_DATA));
  stbpc_host i_host (.i_clk(I_CLK), .i_bsy(I_BSY), .i_sel(I_SEL), .i_req(O_REQ & O_REQ_OE), .i_io(O_IO & O_PHASE_OE),
    .i_db(I_DB), .o_bsy(h_bsy), .o_sel(h_sel), .o_atn(h_atn), .o_ack(h_ack), .o_db(h_db), .o_rx(h_rx),
    .o_rx_byte(h_rx_byte));
  initial forever #25 I_CLK = ~I_CLK;
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_sts(input logic [7:0] m, input logic [7:0] v);
    for (int n = 0; n < 3000 && (sts & m) !== v; n++) @(negedge I_CLK);
    chk("status", v, sts & m);
    I_DONE = 1'b0;
  endtask
  task automatic wait_q();
    for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(negedge I_CLK);
    chk("host_pending", 8'h00, 8'(exp_q.size()));
  endtask
  task automatic pulse(ref logic s);
    @(negedge I_CLK);
    s = 1'b1;
    @(negedge I_CLK);
    s = 1'b0;
  endtask
  // Held until taken or refused
  task automatic req_phase(input logic [2:0] ph, input logic rej, input logic [2:0] exp);
    logic seen;
    seen = 1'b0;
    @(negedge I_CLK);
    I_PHASE = ph;
    I_PHASE_VALID = 1'b1;
    for (int n = 0; n < 400 && !seen && sts[2:0] !== ph; n++) begin
      @(negedge I_CLK);
      seen = (O_CMD_REJECT === 1'b1);
    end
    I_PHASE_VALID = 1'b0;
    repeat (3) @(negedge I_CLK);
    chk("reject", {7'h00, rej}, {7'h00, seen});
    chk("phase", {5'h00, exp}, {5'h00, sts[2:0]});
  endtask
  task automatic push_tx(input int n);
    acc = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge I_CLK);
      I_IN_VALID = 1'b1;
      I_IN_DATA = $random(seed);
      @(posedge I_CLK);
      if (O_IN_READY !== 1'b1) break;
      exp_q.push_back(I_IN_DATA);
      acc++;
    end
    @(negedge I_CLK);
    I_IN_VALID = 1'b0;
  endtask
  always @(negedge I_CLK) I_OUT_READY = drain && ($random(seed) & 1);
  always @(posedge I_CLK) begin
    if (h_rx === 1'b1) chk("host_rx", exp_q.size() ? exp_q.pop_front() : 8'hxx, h_rx_byte);
    if (O_OUT_VALID === 1'b1 && I_OUT_READY === 1'b1)
      chk("user_rx", i_host.sent_q.size() ? i_host.sent_q.pop_front() : 8'hxx, O_OUT_DATA);
  end
  initial begin
    repeat (60000) @(posedge I_CLK);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (16) @(negedge I_CLK);
    I_SYS_RST = 1'b0;
    chk("reset_oe", 8'h00, sts & 8'hf0);
    i_host.tx_q.push_back(8'h06);
    i_host.select(1'b1);
    wait_sts(8'h27, 8'h26);
    wait_sts(8'hf0, 8'h00);
    i_host.o_atn = 1'b0;
    i_host.sent_q.delete();
    repeat (30) i_host.tx_q.push_back($random(seed));
    i_host.select(1'b0);
    wait_sts(8'h27, 8'h22);
    cnt = sts;
    I_CE = 1'b0;
    repeat (60) @(negedge I_CLK);
    chk("ce_hold", 8'(cnt), sts);
    I_CE = 1'b1;
    push_tx(12);
    chk("tx_fill", 8'h01, {7'h00, acc >= 8 && acc <= 9});
    i_host.slow = $random(seed) & 3;
    req_phase(3'h1, 1'b0, 3'h1);
    wait_q();
    req_phase(3'h2, 1'b1, 3'h1);
    for (int p = 4; p < 6; p++) req_phase(3'(p), 1'b1, 3'h1);
    I_SYNC_EN = 1'b1;
    drain = 1'b1;
    req_phase(3'h0, 1'b0, 3'h0);
    chk("sync_active", 8'h01, {7'h00, O_SYNC_ACTIVE});
    repeat (100) @(negedge I_CLK);
    drain = 1'b0;
    repeat (80) @(negedge I_CLK);
    I_SYNC_EN = 1'b0;
    push_tx(1);
    req_phase(3'h3, 1'b0, 3'h3);
    wait_q();
    push_tx(1);
    req_phase(3'h7, 1'b0, 3'h7);
    wait_q();
    I_DONE = 1'b1;
    wait_sts(8'hf0, 8'h00);
    drain = 1'b1;
    repeat (300) @(negedge I_CLK);
    drain = 1'b0;
    chk("rx_left", 8'h00, 8'(i_host.sent_q.size()));
    push_tx(1);
    pulse(I_RESEL_REQ);
    wait_q();
    chk("resel_phase", 8'h07, {5'h00, sts[2:0]});
    I_DONE = 1'b1;
    wait_sts(8'hf0, 8'h00);
    i_host.answer = 1'b0;
    pulse(I_RESEL_REQ);
    cnt = 0;
    acc = 0;
    for (int n = 0; n < 8000 && acc == 0; n++) begin
      @(negedge I_CLK);
      cnt += (O_SEL_OE === 1'b1 && prv == 0);
      prv = O_SEL_OE;
      acc = (O_RESEL_FAIL === 1'b1);
    end
    chk("resel_fail", 8'h01, 8'(acc));
    chk("retry_count", 8'h01, {7'h00, cnt >= 5 && cnt <= 11});
    i_host.select(1'b0);
    wait_sts(8'h27, 8'h22);
    pulse(I_ABORT);
    wait_sts(8'hf0, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
